// File: rtl/mail_irq.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Status cleared by writing one to a bit
// Notes: An event in the clearing cycle keeps its bit set
`default_nettype none

module mail_irq
    import mailbox_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic [EVENT_COUNT-1:0] events, // Event pulses
    input wire logic status_wr, // Status write strobe
    input wire logic mask_wr, // Mask write strobe
    input wire logic [EVENT_COUNT-1:0] wdata, // Write data
    output logic [EVENT_COUNT-1:0] status_r, // Sticky status
    output logic [EVENT_COUNT-1:0] mask_r, // Enable mask
    output logic irq_r // Level interrupt
);

    genvar i;
    generate
        for (i = 0; i < EVENT_COUNT; i++) begin : g_bit
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    status_r[i] <= IRQ_STATUS_RESET[i];
                end else if (events[i]) begin
                    status_r[i] <= 1'b1;
                end else if (status_wr && wdata[i]) begin
                    status_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= IRQ_MASK_RESET;
        end else if (mask_wr) begin
            mask_r <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

endmodule

`default_nettype wire

// File: rtl/mail_slot.sv
// Purpose: One mail register with its active-low full flag
// Assumes: Writer and reader both on the single clock
// Notes: Flush wins over a write; a write wins over a read
`default_nettype none

module mail_slot
    import mailbox_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic flush, // Queue reset or software flush
    input wire logic wr, // Mail write attempt
    input wire logic [MAIL_WIDTH-1:0] wdata, // Mail write data
    input wire logic rd, // Mail read by far port
    output logic full_n_r, // Low while mail waits
    output logic [MAIL_WIDTH-1:0] data_r, // Stored mail word
    output mail_event_t ev // One-cycle event pulses
);

    logic accept;

    assign accept = wr && full_n_r && !flush;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            full_n_r <= 1'b1;
        end else if (flush) begin
            full_n_r <= 1'b1;
        end else if (accept) begin
            full_n_r <= 1'b0;
        end else if (rd) begin
            full_n_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_r <= MAIL_DATA_RESET;
        end else if (accept) begin
            data_r <= wdata;
        end
    end

    assign ev.written = accept;
    assign ev.taken = rd && !full_n_r && !flush && !accept;
    // A blocked write is reported so software sees lost mail
    assign ev.dropped = wr && !full_n_r && !flush;

endmodule

`default_nettype wire

// File: rtl/mailbox_pkg.sv
// Purpose: Shared constants and types for the triple-port mailbox bypass logic
// Assumes: One clock; all three ports sampled on it
// Notes: Register indices are word addresses on the plain register port
`default_nettype none

package mailbox_pkg;

    // ********************************
    // Widths
    // ********************************
    localparam int A_WIDTH = 36;
    localparam int BC_WIDTH = 18;
    localparam int MAIL_WIDTH = 18;
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;
    localparam int EVENT_COUNT = 6;

    // ********************************
    // Register map (word index)
    // ********************************
    localparam logic [REG_AW-1:0] IRQ_STATUS_ADDR = 4'h0;
    localparam logic [REG_AW-1:0] IRQ_MASK_ADDR = 4'h1;
    localparam logic [REG_AW-1:0] MAIL_CONTROL_ADDR = 4'h2;
    localparam logic [REG_AW-1:0] MAIL_STATE_ADDR = 4'h3;

    // ********************************
    // Event bits of status and mask
    // ********************************
    localparam int EV_AB_WRITTEN = 0;
    localparam int EV_AB_TAKEN = 1;
    localparam int EV_AB_DROPPED = 2;
    localparam int EV_CA_WRITTEN = 3;
    localparam int EV_CA_TAKEN = 4;
    localparam int EV_CA_DROPPED = 5;

    // ********************************
    // Control bits (self-clearing)
    // ********************************
    localparam int CTL_FLUSH_AB = 0;
    localparam int CTL_FLUSH_CA = 1;

    // ********************************
    // State register fields
    // ********************************
    localparam int ST_AB_FULL_N = 0;
    localparam int ST_CA_FULL_N = 1;
    localparam int ST_SEL_A = 2;
    localparam int ST_SEL_B = 3;
    localparam int ST_SEL_C = 4;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [EVENT_COUNT-1:0] IRQ_STATUS_RESET = 6'h00;
    localparam logic [EVENT_COUNT-1:0] IRQ_MASK_RESET = 6'h00;
    localparam logic [MAIL_WIDTH-1:0] MAIL_DATA_RESET = 18'h00000;
    localparam logic [A_WIDTH-1:0] A_OUT_RESET = 36'h000000000;
    localparam logic [BC_WIDTH-1:0] B_OUT_RESET = 18'h00000;
    localparam logic [REG_DW-1:0] RDATA_RESET = 32'h00000000;

    typedef struct packed {
        logic write;
        logic read;
        logic [REG_AW-1:0] addr;
        logic [REG_DW-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic written;
        logic taken;
        logic dropped;
    } mail_event_t;

endpackage

`default_nettype wire

// File: rtl/triple_port_mailbox_flags.sv
// Purpose: Mailbox bypass between port A and ports B and C, with full flags
// Assumes: All port strobes and selects synchronous to CLOCK; queues outside
// Notes: Port data outputs are registered, one cycle behind the select
//
// Operation
// - Port B shows A-to-B mail when selected
// - Port B shows forward queue when not selected
// - Selected port C write goes to mail
// - Accepted A-to-B mail write drives flag low
// - A-to-B mail writes ignored while flag low
// - Selected port B mail read sets flag high
// - Forward queue resets hold A-to-B flag high
// - Accepted C-to-A mail write drives flag low
// - C-to-A mail writes ignored while flag low
// - Selected port A mail read sets flag high
// - Return queue resets hold C-to-A flag high
// - Port A shows mail or return queue data
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none

module triple_port_mailbox_flags
    import mailbox_pkg::*;
(
    input wire logic CLOCK, // 250 MHz clock
    input wire logic RSTN, // Async reset, active low
    input wire logic MASTER_RESET_FWD_N, // Forward queue master reset
    input wire logic PARTIAL_RESET_FWD_N, // Forward queue partial reset
    input wire logic MASTER_RESET_RET_N, // Return queue master reset
    input wire logic PARTIAL_RESET_RET_N, // Return queue partial reset
    input wire logic PORT_A_MAIL_SELECT, // Port A mail select
    input wire logic PORT_A_WRITE, // Port A write strobe
    input wire logic PORT_A_READ, // Port A read strobe
    input wire logic PORT_A_OUT_ENABLE, // Port A outputs requested
    input wire logic [A_WIDTH-1:0] PORT_A_DIN, // Port A write data
    input wire logic [A_WIDTH-1:0] RETURN_QUEUE_DATA, // Return queue output reg
    output logic [A_WIDTH-1:0] PORT_A_DOUT, // Port A read data
    output logic PORT_A_DOE, // Port A drive enable
    output logic FORWARD_QUEUE_WRITE, // Forward queue write pulse
    output logic [A_WIDTH-1:0] FORWARD_QUEUE_WDATA, // Forward queue write data
    input wire logic PORT_B_MAIL_SELECT, // Port B mail select
    input wire logic PORT_B_READ, // Port B read strobe
    input wire logic PORT_B_OUT_ENABLE, // Port B outputs requested
    input wire logic [BC_WIDTH-1:0] FORWARD_QUEUE_DATA, // Forward queue output reg
    output logic [BC_WIDTH-1:0] PORT_B_DOUT, // Port B data
    output logic PORT_B_DOE, // Port B drive enable
    input wire logic PORT_C_MAIL_SELECT, // Port C mail select
    input wire logic PORT_C_WRITE, // Port C write strobe
    input wire logic [BC_WIDTH-1:0] PORT_C_DIN, // Port C write data
    output logic RETURN_QUEUE_WRITE, // Return queue write pulse
    output logic [BC_WIDTH-1:0] RETURN_QUEUE_WDATA, // Return queue write data
    output logic MAIL_A_TO_B_FULL_N, // A-to-B mail waiting, low
    output logic MAIL_C_TO_A_FULL_N, // C-to-A mail waiting, low
    input wire logic [REG_AW-1:0] REG_ADDR, // Register word index
    input wire logic [REG_DW-1:0] REG_WDATA, // Register write data
    input wire logic REG_WRITE, // Register write strobe
    input wire logic REG_READ, // Register read strobe
    output logic [REG_DW-1:0] REG_RDATA, // Read data, next cycle
    output logic IRQ // Level interrupt, high
);

    // ********************************
    // Internal signals
    // ********************************
    reg_req_t req;
    mail_event_t ev_ab;
    mail_event_t ev_ca;
    logic flush_ab;
    logic flush_ca;
    logic ab_wr;
    logic ab_rd;
    logic ca_wr;
    logic ca_rd;
    logic [MAIL_WIDTH-1:0] mail_a_to_b_reg;
    logic [MAIL_WIDTH-1:0] mail_c_to_a_reg;
    logic [EVENT_COUNT-1:0] events;
    logic [EVENT_COUNT-1:0] status;
    logic [EVENT_COUNT-1:0] mask;
    logic status_wr;
    logic mask_wr;
    logic control_wr;
    logic [REG_DW-1:0] rdata_nxt;

    assign req = '{write: REG_WRITE, read: REG_READ, addr: REG_ADDR, wdata: REG_WDATA};
    assign status_wr = req.write && (req.addr == IRQ_STATUS_ADDR);
    assign mask_wr = req.write && (req.addr == IRQ_MASK_ADDR);
    assign control_wr = req.write && (req.addr == MAIL_CONTROL_ADDR);

    // ********************************
    // Mail access decode
    // ********************************
    assign ab_wr = PORT_A_WRITE && PORT_A_MAIL_SELECT;
    assign ab_rd = PORT_B_READ && PORT_B_MAIL_SELECT;
    // Port C select is held high in master reset, so no queue write leaks
    assign ca_wr = PORT_C_WRITE && PORT_C_MAIL_SELECT;
    assign ca_rd = PORT_A_READ && PORT_A_MAIL_SELECT;

    // Either queue reset, or a software flush, empties the mailbox
    assign flush_ab = !MASTER_RESET_FWD_N || !PARTIAL_RESET_FWD_N ||
                      (control_wr && req.wdata[CTL_FLUSH_AB]);
    assign flush_ca = !MASTER_RESET_RET_N || !PARTIAL_RESET_RET_N ||
                      (control_wr && req.wdata[CTL_FLUSH_CA]);

    // ********************************
    // Mail registers
    // ********************************
    mail_slot u_mail_ab (
        .clk(CLOCK),
        .rstn(RSTN),
        .flush(flush_ab),
        .wr(ab_wr),
        .wdata(PORT_A_DIN[MAIL_WIDTH-1:0]),
        .rd(ab_rd),
        .full_n_r(MAIL_A_TO_B_FULL_N),
        .data_r(mail_a_to_b_reg),
        .ev(ev_ab)
    );

    mail_slot u_mail_ca (
        .clk(CLOCK),
        .rstn(RSTN),
        .flush(flush_ca),
        .wr(ca_wr),
        .wdata(PORT_C_DIN),
        .rd(ca_rd),
        .full_n_r(MAIL_C_TO_A_FULL_N),
        .data_r(mail_c_to_a_reg),
        .ev(ev_ca)
    );

    // ********************************
    // Port A output
    // ********************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            PORT_A_DOUT <= A_OUT_RESET;
        end else if (PORT_A_MAIL_SELECT) begin
            PORT_A_DOUT <= {{(A_WIDTH-MAIL_WIDTH){1'b0}}, mail_c_to_a_reg};
        end else begin
            PORT_A_DOUT <= RETURN_QUEUE_DATA;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            PORT_A_DOE <= 1'b0;
        end else begin
            PORT_A_DOE <= PORT_A_OUT_ENABLE;
        end
    end

    // ********************************
    // Port A write into forward queue
    // ********************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            FORWARD_QUEUE_WRITE <= 1'b0;
            FORWARD_QUEUE_WDATA <= A_OUT_RESET;
        end else begin
            FORWARD_QUEUE_WRITE <= PORT_A_WRITE && !PORT_A_MAIL_SELECT;
            FORWARD_QUEUE_WDATA <= PORT_A_DIN;
        end
    end

    // ********************************
    // Port B output
    // ********************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            PORT_B_DOUT <= B_OUT_RESET;
        end else if (PORT_B_MAIL_SELECT) begin
            PORT_B_DOUT <= mail_a_to_b_reg;
        end else begin
            PORT_B_DOUT <= FORWARD_QUEUE_DATA;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            PORT_B_DOE <= 1'b0;
        end else begin
            PORT_B_DOE <= PORT_B_OUT_ENABLE;
        end
    end

    // ********************************
    // Port C write into return queue
    // ********************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            RETURN_QUEUE_WRITE <= 1'b0;
            RETURN_QUEUE_WDATA <= B_OUT_RESET;
        end else begin
            RETURN_QUEUE_WRITE <= PORT_C_WRITE && !PORT_C_MAIL_SELECT;
            RETURN_QUEUE_WDATA <= PORT_C_DIN;
        end
    end

    // ********************************
    // Events and interrupt
    // ********************************
    assign events[EV_AB_WRITTEN] = ev_ab.written;
    assign events[EV_AB_TAKEN] = ev_ab.taken;
    assign events[EV_AB_DROPPED] = ev_ab.dropped;
    assign events[EV_CA_WRITTEN] = ev_ca.written;
    assign events[EV_CA_TAKEN] = ev_ca.taken;
    assign events[EV_CA_DROPPED] = ev_ca.dropped;

    mail_irq u_irq (
        .clk(CLOCK),
        .rstn(RSTN),
        .events(events),
        .status_wr(status_wr),
        .mask_wr(mask_wr),
        .wdata(req.wdata[EVENT_COUNT-1:0]),
        .status_r(status),
        .mask_r(mask),
        .irq_r(IRQ)
    );

    // ********************************
    // Register read port
    // ********************************
    always_comb begin
        rdata_nxt = RDATA_RESET;
        if (req.read) begin
            case (req.addr)
                IRQ_STATUS_ADDR: rdata_nxt[EVENT_COUNT-1:0] = status;
                IRQ_MASK_ADDR: rdata_nxt[EVENT_COUNT-1:0] = mask;
                MAIL_STATE_ADDR: begin
                    rdata_nxt[ST_AB_FULL_N] = MAIL_A_TO_B_FULL_N;
                    rdata_nxt[ST_CA_FULL_N] = MAIL_C_TO_A_FULL_N;
                    rdata_nxt[ST_SEL_A] = PORT_A_MAIL_SELECT;
                    rdata_nxt[ST_SEL_B] = PORT_B_MAIL_SELECT;
                    rdata_nxt[ST_SEL_C] = PORT_C_MAIL_SELECT;
                end
                default: rdata_nxt = RDATA_RESET;
            endcase
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= RDATA_RESET;
        end else begin
            REG_RDATA <= rdata_nxt;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    AST_B_MAIL_OUT: assert property (@(posedge CLOCK) disable iff (!RSTN)
        PORT_B_MAIL_SELECT |=> PORT_B_DOUT == $past(mail_a_to_b_reg))
        else $error("Port B did not show A-to-B mail");

    AST_B_QUEUE_OUT: assert property (@(posedge CLOCK) disable iff (!RSTN)
        RSTN && !PORT_B_MAIL_SELECT |=> PORT_B_DOUT == $past(FORWARD_QUEUE_DATA))
        else $error("Port B did not show forward queue data");

    AST_C_STEER: assert property (@(posedge CLOCK) disable iff (!RSTN)
        PORT_C_WRITE && PORT_C_MAIL_SELECT && MAIL_C_TO_A_FULL_N && !flush_ca
        |=> !RETURN_QUEUE_WRITE && !MAIL_C_TO_A_FULL_N
            && mail_c_to_a_reg == $past(PORT_C_DIN))
        else $error("Selected port C write not steered to mail");

    AST_AB_SET: assert property (@(posedge CLOCK) disable iff (!RSTN)
        ab_wr && MAIL_A_TO_B_FULL_N && !flush_ab
        |=> !MAIL_A_TO_B_FULL_N && mail_a_to_b_reg == $past(PORT_A_DIN[MAIL_WIDTH-1:0]))
        else $error("A-to-B flag not set by mail write");

    AST_AB_HOLD: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !MAIL_A_TO_B_FULL_N && ab_wr |=> $stable(mail_a_to_b_reg))
        else $error("A-to-B mail overwritten while full");

    AST_AB_CLEAR: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !MAIL_A_TO_B_FULL_N && ab_rd |=> MAIL_A_TO_B_FULL_N)
        else $error("A-to-B flag not cleared by port B read");

    AST_AB_FLUSH: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !MASTER_RESET_FWD_N || !PARTIAL_RESET_FWD_N |=> MAIL_A_TO_B_FULL_N)
        else $error("A-to-B flag low after forward queue reset");

    AST_CA_SET: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $fell(MAIL_C_TO_A_FULL_N) |-> $past(ca_wr))
        else $error("C-to-A flag fell without a mail write");

    AST_CA_HOLD: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !MAIL_C_TO_A_FULL_N && ca_wr |=> $stable(mail_c_to_a_reg))
        else $error("C-to-A mail overwritten while full");

    AST_CA_CLEAR: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !MAIL_C_TO_A_FULL_N && ca_rd |=> MAIL_C_TO_A_FULL_N)
        else $error("C-to-A flag not cleared by port A read");

    AST_CA_FLUSH: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !MASTER_RESET_RET_N || !PARTIAL_RESET_RET_N |=> MAIL_C_TO_A_FULL_N)
        else $error("C-to-A flag low after return queue reset");

    AST_A_OUT: assert property (@(posedge CLOCK) disable iff (!RSTN)
        PORT_A_MAIL_SELECT |=> PORT_A_DOUT[MAIL_WIDTH-1:0] == $past(mail_c_to_a_reg)
            && PORT_A_DOUT[A_WIDTH-1:MAIL_WIDTH] == '0)
        else $error("Port A did not show C-to-A mail");

endmodule

`default_nettype wire

// File: sim/queue_partner.sv
// Purpose: Stand-in for the forward and return queue output registers
// Assumes: Queue storage lives outside the mailbox block
// Notes: Values move every cycle so stale or misrouted data shows up
`default_nettype none

module queue_partner
    import mailbox_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    output logic [BC_WIDTH-1:0] fwd_data, // Forward queue output reg
    output logic [A_WIDTH-1:0] ret_data // Return queue output reg
);
    timeunit 1ns;
    timeprecision 1ps;

    // Never holds a value, so a select that is ignored cannot hide
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fwd_data <= 18'h2aaaa;
            ret_data <= 36'h5a5a5a5a5;
        end else begin
            fwd_data <= fwd_data + 18'h0b3d7;
            ret_data <= ret_data + 36'h123456789;
        end
    end
endmodule

`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the mailbox bypass and its full flags
// Assumes: One clock; strobes driven by non-blocking assignment at rising edges
// Notes: Driver queues expected results, a monitor pops them as they appear
`default_nettype none

module tb
    import mailbox_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 0, rstn = 0, a_sel = 0, a_wr = 0, a_rd = 0, a_oe = 1;
    logic b_sel = 0, b_rd = 0, b_oe = 1, c_sel = 1, c_wr = 0, r_wr = 0, r_rd = 0;
    logic [3:0] qr_n = 4'hf;
    logic [35:0] a_din = 36'h0, a_dout, fq_wdata, rq_data;
    logic [17:0] c_din = 18'h0, b_dout, rq_wdata, fq_data, ab_mail, ca_mail;
    logic [3:0] r_addr = 4'h0;
    logic [31:0] r_wdata = 32'h0, r_rdata;
    logic a_doe, b_doe, fq_wr, rq_wr, ab_full_n, ca_full_n, irq;
    logic rd_q = 0, ard_q = 0, brd_q = 0, ab_f = 1, ca_f = 1;
    logic [35:0] exp_q[$];
    int miscompares = 0, compares = 0;

    triple_port_mailbox_flags u_dut (.CLOCK(clk), .RSTN(rstn),
        .MASTER_RESET_FWD_N(qr_n[0]), .PARTIAL_RESET_FWD_N(qr_n[1]),
        .MASTER_RESET_RET_N(qr_n[2]), .PARTIAL_RESET_RET_N(qr_n[3]),
        .PORT_A_MAIL_SELECT(a_sel), .PORT_A_WRITE(a_wr), .PORT_A_READ(a_rd),
        .PORT_A_OUT_ENABLE(a_oe), .PORT_A_DIN(a_din), .RETURN_QUEUE_DATA(rq_data),
        .PORT_A_DOUT(a_dout), .PORT_A_DOE(a_doe), .FORWARD_QUEUE_WRITE(fq_wr),
        .FORWARD_QUEUE_WDATA(fq_wdata), .PORT_B_MAIL_SELECT(b_sel), .PORT_B_READ(b_rd),
        .PORT_B_OUT_ENABLE(b_oe), .FORWARD_QUEUE_DATA(fq_data), .PORT_B_DOUT(b_dout),
        .PORT_B_DOE(b_doe), .PORT_C_MAIL_SELECT(c_sel), .PORT_C_WRITE(c_wr),
        .PORT_C_DIN(c_din), .RETURN_QUEUE_WRITE(rq_wr), .RETURN_QUEUE_WDATA(rq_wdata),
        .MAIL_A_TO_B_FULL_N(ab_full_n), .MAIL_C_TO_A_FULL_N(ca_full_n),
        .REG_ADDR(r_addr), .REG_WDATA(r_wdata), .REG_WRITE(r_wr), .REG_READ(r_rd),
        .REG_RDATA(r_rdata), .IRQ(irq));

    queue_partner u_partner (.clk(clk), .rstn(rstn), .fwd_data(fq_data),
        .ret_data(rq_data));

    always #2 clk = ~clk;

    // ********************************
    // Checking
    // ********************************
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pop_chk(input logic [35:0] seen);
        if (exp_q.size() == 0) begin
            miscompares++;
            $display("[ERR] %0t result with nothing expected", $time);
        end else begin
            chk(seen, exp_q.pop_front());
        end
    endtask

    task automatic flag();
        @(negedge clk);
        chk({32'h0, a_doe, b_doe, ab_full_n, ca_full_n}, {32'h0, a_oe, b_oe, ab_f, ca_f});
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        rd_q <= r_rd;
        ard_q <= a_rd;
        brd_q <= b_rd;
    end

    // Results checked at the falling edge after the sampling edge
    always @(negedge clk) begin
        if (rstn) begin
            if (rd_q) pop_chk({4'h0, r_rdata});
            if (ard_q) pop_chk(a_dout);
            if (brd_q) pop_chk({18'h0, b_dout});
            if (fq_wr) pop_chk(fq_wdata);
            if (rq_wr) pop_chk({18'h0, rq_wdata});
        end
    end

    // ********************************
    // Drivers
    // ********************************
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        r_addr <= a;
        r_wdata <= d;
        r_wr <= 1;
        @(posedge clk);
        r_wr <= 0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        r_addr <= a;
        r_rd <= 1;
        exp_q.push_back({4'h0, e});
        @(posedge clk);
        r_rd <= 0;
        @(posedge clk);
    endtask

    task automatic a_op(input logic sel, input logic wr, input logic [35:0] d);
        a_sel <= sel;
        a_wr <= wr;
        a_rd <= !wr;
        a_din <= d;
        if (wr && !sel) exp_q.push_back(d);
        @(negedge clk);
        if (!wr) exp_q.push_back(sel ? {18'h0, ca_mail} : rq_data);
        @(posedge clk);
        a_wr <= 0;
        a_rd <= 0;
        if (wr && sel && ab_f) ab_mail = d[17:0];
        if (sel) ab_f = wr ? 1'b0 : ab_f;
        if (sel && !wr) ca_f = 1;
        @(posedge clk);
    endtask

    task automatic b_op(input logic sel);
        b_sel <= sel;
        b_rd <= 1;
        @(negedge clk);
        exp_q.push_back({18'h0, sel ? ab_mail : fq_data});
        @(posedge clk);
        b_rd <= 0;
        if (sel) ab_f = 1;
        @(posedge clk);
    endtask

    task automatic c_op(input logic sel, input logic [17:0] d);
        c_sel <= sel;
        c_wr <= 1;
        c_din <= d;
        if (!sel) exp_q.push_back({18'h0, d});
        @(posedge clk);
        c_wr <= 0;
        if (sel && ca_f) ca_mail = d;
        if (sel) ca_f = 0;
        @(posedge clk);
    endtask

    // Queue resets; port C select stays high across master resets
    task automatic qreset(input int i);
        qr_n[i] <= 0;
        if (i == 0 || i == 2) c_sel <= 1;
        @(posedge clk);
        qr_n[i] <= 1;
        if (i < 2) ab_f = 1;
        else ca_f = 1;
        @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #40000;
        miscompares++;
        tally_and_finish();
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        void'($urandom(32'h5c46));
        repeat (12) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        flag();
        reg_rd(MAIL_STATE_ADDR, 32'h13);
        reg_rd(IRQ_STATUS_ADDR, 32'h0);
        reg_rd(IRQ_MASK_ADDR, 32'h0);
        reg_rd(MAIL_CONTROL_ADDR, 32'h0);
        reg_rd(4'hf, 32'h0);
        $display("test reset values done");
        // Writer ignores the flag; the second write is meant to be lost
        a_op(1, 1, {4'($urandom()), $urandom()});
        flag();
        a_op(1, 1, {4'($urandom()), $urandom()});
        flag();
        b_op(1);
        flag();
        b_op(0);
        a_op(0, 1, {4'($urandom()), $urandom()});
        reg_rd(IRQ_STATUS_ADDR, 32'h07);
        $display("test port A to B mail done");
        c_op(1, 18'($urandom()));
        flag();
        c_op(1, 18'($urandom()));
        flag();
        a_op(1, 0, 36'h0);
        flag();
        a_op(0, 0, 36'h0);
        c_op(0, 18'($urandom()));
        reg_rd(IRQ_STATUS_ADDR, 32'h3f);
        $display("test port C to A mail done");
        for (int i = 0; i < 4; i++) begin
            if (i < 2) a_op(1, 1, {4'($urandom()), $urandom()});
            else c_op(1, 18'($urandom()));
            flag();
            qreset(i);
            flag();
        end
        $display("test queue resets done");
        reg_wr(IRQ_STATUS_ADDR, 32'h3f);
        reg_wr(IRQ_MASK_ADDR, 32'h01);
        a_op(1, 1, {4'($urandom()), $urandom()});
        @(negedge clk);
        chk({35'h0, irq}, 36'h1);
        @(posedge clk);
        reg_rd(IRQ_STATUS_ADDR, 32'h01);
        reg_rd(MAIL_STATE_ADDR, {27'h0, c_sel, b_sel, a_sel, 2'b10});
        c_op(1, 18'($urandom()));
        reg_wr(IRQ_STATUS_ADDR, 32'h01);
        @(negedge clk);
        chk({35'h0, irq}, 36'h0);
        @(posedge clk);
        reg_wr(MAIL_CONTROL_ADDR, 32'h3);
        ab_f = 1;
        ca_f = 1;
        flag();
        $display("test interrupt and flush done");
        a_oe <= 0;
        b_oe <= 0;
        @(posedge clk);
        flag();
        $display("test output enables done");
        repeat (2) @(posedge clk);
        chk(36'(exp_q.size()), 36'h0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
